// file: inc/adc_pkg.sv
// shared constants and types for the sleep-start converter control block
package adc_pkg;

    // ----------------------------------------
    // register map (byte offsets)
    // ----------------------------------------
    localparam logic [4:0] CTRL_OFS = 5'h00;
    localparam logic [4:0] RES_LOW_OFS = 5'h04;
    localparam logic [4:0] RES_HIGH_OFS = 5'h08;
    localparam logic [4:0] IRQ_STATUS_OFS = 5'h0C;
    localparam logic [4:0] IRQ_CLEAR_OFS = 5'h10;
    localparam logic [4:0] IRQ_ENABLE_OFS = 5'h14;
    localparam logic [4:0] STATE_OFS = 5'h18;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_LEFT_BIT = 2;
    localparam int CTRL_DIFF_BIT = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int STATE_BUSY_BIT = 0;
    localparam int STATE_FIRST_BIT = 1;
    localparam int STATE_SLEEP_BIT = 2;

    // ----------------------------------------
    // reset values and codes
    // ----------------------------------------
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] SE_MAX_CODE = 10'h3FF;
    localparam logic [9:0] SE_MIN_CODE = 10'h000;
    localparam logic [9:0] DIFF_MAX_CODE = 10'h1FF;
    localparam logic [9:0] DIFF_MIN_CODE = 10'h200;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    // ----------------------------------------
    // timing counts in converter clock cycles, and system clock cycles per converter clock cycle
    // ----------------------------------------
    localparam int NORMAL_CONV_CYCLES = 13;
    localparam int FIRST_CONV_CYCLES = 25;
    localparam int CONV_CLK_DIV = 2;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [2:0] {
        SLEEP_IDLE,
        SLEEP_LOW_NOISE,
        SLEEP_POWER_DOWN,
        SLEEP_POWER_SAVE,
        SLEEP_STANDBY
    } sleep_mode_e;

    typedef struct packed {
        logic differential;
        logic left_adjust_select;
        logic conversion_start_bit;
        logic converter_enable;
    } ctrl_s;

    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } result_bytes_s;

endpackage

// file: hw/result_formatter.sv
// clamps the raw converter estimate and places the stored code into the two result bytes
`timescale 1ns/100ps
`default_nettype none
module result_formatter (
    input wire logic signed [11:0] raw_value,
    input wire logic differential,
    input wire logic [9:0] stored_code,
    input wire logic left_adjust_select,
    output logic [9:0] clamped_code,
    output adc_pkg::result_bytes_s bytes
);

    always_comb begin
        if (differential) begin
            if (raw_value > 12'sd511) begin
                clamped_code = adc_pkg::DIFF_MAX_CODE;
            end else if (raw_value < -12'sd512) begin
                clamped_code = adc_pkg::DIFF_MIN_CODE;
            end else begin
                clamped_code = raw_value[9:0];
            end
        end else begin
            // above reference saturates at full scale
            if (raw_value > 12'sd1023) begin
                clamped_code = adc_pkg::SE_MAX_CODE;
            end else if (raw_value < 12'sd0) begin
                clamped_code = adc_pkg::SE_MIN_CODE;
            end else begin
                clamped_code = raw_value[9:0];
            end
        end
    end

    // left or right adjusted byte split
    always_comb begin
        if (left_adjust_select) begin
            bytes.result_high_byte = stored_code[9:2];
            bytes.result_low_byte = {stored_code[1:0], 6'h00};
        end else begin
            bytes.result_high_byte = {6'h00, stored_code[9:8]};
            bytes.result_low_byte = stored_code[7:0];
        end
    end

endmodule
`default_nettype wire

// file: hw/conversion_timer.sv
// counts system clock cycles of one conversion, DIV per converter clock cycle, from start to completion
`timescale 1ns/100ps
`default_nettype none
module conversion_timer #(
    parameter int DIV = adc_pkg::CONV_CLK_DIV,
    parameter int NORMAL = adc_pkg::NORMAL_CONV_CYCLES,
    parameter int FIRST = adc_pkg::FIRST_CONV_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic first,
    input wire logic abort,
    output logic busy,
    output logic done
);

    localparam int TOTAL_W = $clog2(FIRST * DIV + 1);
    localparam logic [TOTAL_W-1:0] LEN_NORMAL = TOTAL_W'(NORMAL * DIV);
    localparam logic [TOTAL_W-1:0] LEN_FIRST = TOTAL_W'(FIRST * DIV);

    logic [TOTAL_W-1:0] left_reg;

    always_ff @(posedge clock) begin
        if (!rst_n || abort) begin
            left_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                left_reg <= first ? LEN_FIRST : LEN_NORMAL;
                busy <= 1'b1;
            end else if (busy) begin
                if (left_reg == TOTAL_W'(1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                left_reg <= left_reg - TOTAL_W'(1);
            end
        end
    end

endmodule
`default_nettype wire

// file: hw/adc_ctrl.sv
// converter control: registers, sleep-started conversions, result and interrupt
//
// Overview of operation
// - halting in idle or low-noise sleep, enabled and idle, starts a conversion
// - completion of a sleep-started conversion raises the interrupt that wakes
// - done request is posted even when another interrupt woke the core first
// - other sleep modes leave the enable bit as software left it
// - once the done flag is high the result bytes hold the result
// - single-ended result is an unsigned ten-bit code, 0x000 to 0x3FF
// - single-ended overrange saturates at 0x3FF, never wraps
// - differential result is two's complement from 0x200 to 0x1FF
// - bit nine of a differential result is the sign
// - left adjust chooses which bits land in the high and low bytes
// - completion stores the result, sets the flag, clears the start bit
// - left adjust change shows on the result bytes at once
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl #(
    parameter int CLK_DIV = adc_pkg::CONV_CLK_DIV,
    parameter int NORMAL_CYCLES = adc_pkg::NORMAL_CONV_CYCLES,
    parameter int FIRST_CYCLES = adc_pkg::FIRST_CONV_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic cpu_halted,
    input wire logic [2:0] sleep_mode,
    input wire logic signed [11:0] raw_value,
    output logic irq,
    output logic converter_powered,
    output logic conversion_active,
    output logic sample_latch
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    adc_pkg::ctrl_s ctrl_reg;
    adc_pkg::result_bytes_s bytes;
    logic [9:0] result_reg;
    logic [9:0] clamped_code;
    logic done_flag_reg;
    logic done_enable_reg;
    logic first_pending_reg;
    logic halted_prev_reg;
    logic sleep_started_reg;
    logic timer_busy;
    logic timer_done;
    logic req_seen;
    logic take_write;
    logic start_request;
    logic sleep_entry;
    logic low_noise_sleep;
    logic clear_done;
    logic ctrl_write;
    logic [31:0] read_mux;

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    // one wait cycle per access: readdata is captured while waitrequest
    // is high and stands when it drops, so the master sees it at that edge
    assign req_seen = (read || write) && waitrequest;
    assign take_write = write && !waitrequest;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !req_seen;
        end
    end

    // ----------------------------------------
    // register write decode
    // ----------------------------------------
    assign ctrl_write = take_write && (address == adc_pkg::CTRL_OFS) && byteenable[0];
    assign clear_done = take_write && (address == adc_pkg::IRQ_CLEAR_OFS)
        && byteenable[0] && writedata[adc_pkg::IRQ_DONE_BIT];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_enable_reg <= 1'b0;
        end else if (take_write && (address == adc_pkg::IRQ_ENABLE_OFS) && byteenable[0]) begin
            done_enable_reg <= writedata[adc_pkg::IRQ_DONE_BIT];
        end
    end

    // ----------------------------------------
    // control bits
    // ----------------------------------------
    // enable, adjust and mode follow software only; sleep never touches
    // them, so a deep sleep with the converter on keeps burning power
    // start bit shares this process: one driver for the whole struct
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= adc_pkg::CTRL_RESET;
        end else begin
            if (ctrl_write) begin
                ctrl_reg.converter_enable <= writedata[adc_pkg::CTRL_ENABLE_BIT];
                // adjust applies to the stored result at once
                ctrl_reg.left_adjust_select <= writedata[adc_pkg::CTRL_LEFT_BIT];
                ctrl_reg.differential <= writedata[adc_pkg::CTRL_DIFF_BIT];
            end
            if (!ctrl_reg.converter_enable) begin
                ctrl_reg.conversion_start_bit <= 1'b0;
            end else if (start_request) begin
                ctrl_reg.conversion_start_bit <= 1'b1;
            end else if (timer_done) begin
                ctrl_reg.conversion_start_bit <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // sleep entry detection
    // ----------------------------------------
    assign low_noise_sleep = (sleep_mode == 3'(adc_pkg::SLEEP_IDLE))
        || (sleep_mode == 3'(adc_pkg::SLEEP_LOW_NOISE));
    assign sleep_entry = cpu_halted && !halted_prev_reg && low_noise_sleep;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            halted_prev_reg <= 1'b0;
        end else begin
            halted_prev_reg <= cpu_halted;
        end
    end

    // ----------------------------------------
    // conversion start
    // ----------------------------------------
    // halt edge in a quiet mode starts one conversion when idle
    // the sleep start rides the same path as a software start
    assign start_request = ctrl_reg.converter_enable && !ctrl_reg.conversion_start_bit
        && ((ctrl_write && writedata[adc_pkg::CTRL_START_BIT]) || sleep_entry);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sleep_started_reg <= 1'b0;
        end else if (start_request) begin
            sleep_started_reg <= sleep_entry && !(ctrl_write && writedata[adc_pkg::CTRL_START_BIT]);
        end else if (timer_done || !ctrl_reg.converter_enable) begin
            sleep_started_reg <= 1'b0;
        end
    end

    // first conversion after enable runs the longer initialising count
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            first_pending_reg <= 1'b1;
        end else if (!ctrl_reg.converter_enable) begin
            first_pending_reg <= 1'b1;
        end else if (start_request) begin
            first_pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // timing and formatting
    // ----------------------------------------
    conversion_timer #(
        .DIV(CLK_DIV),
        .NORMAL(NORMAL_CYCLES),
        .FIRST(FIRST_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .start(start_request),
        .first(first_pending_reg),
        .abort(!ctrl_reg.converter_enable),
        .busy(timer_busy),
        .done(timer_done)
    );

    result_formatter u_format (
        .raw_value(raw_value),
        .differential(ctrl_reg.differential),
        .stored_code(result_reg),
        .left_adjust_select(ctrl_reg.left_adjust_select),
        .clamped_code(clamped_code),
        .bytes(bytes)
    );

    // ----------------------------------------
    // result and done flag
    // ----------------------------------------
    // result stored on the completion edge
    // flag and stored result rise together
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_reg <= adc_pkg::RESULT_RESET;
        end else if (timer_done) begin
            result_reg <= clamped_code;
        end
    end

    // set beats a clear in the same cycle so no completion is lost
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
        end else if (timer_done) begin
            done_flag_reg <= 1'b1;
        end else if (clear_done) begin
            done_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt and pins
    // ----------------------------------------
    // the done interrupt doubles as the wake request
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (done_flag_reg || timer_done) && done_enable_reg
                && !(clear_done && !timer_done);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            converter_powered <= 1'b0;
            conversion_active <= 1'b0;
            sample_latch <= 1'b0;
        end else begin
            converter_powered <= ctrl_reg.converter_enable;
            conversion_active <= timer_busy;
            // the analog side holds its sample on this pulse
            sample_latch <= start_request;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        read_mux = adc_pkg::UNMAPPED_READ;
        unique case (address)
            adc_pkg::CTRL_OFS: begin
                read_mux[adc_pkg::CTRL_ENABLE_BIT] = ctrl_reg.converter_enable;
                read_mux[adc_pkg::CTRL_START_BIT] = ctrl_reg.conversion_start_bit;
                read_mux[adc_pkg::CTRL_LEFT_BIT] = ctrl_reg.left_adjust_select;
                read_mux[adc_pkg::CTRL_DIFF_BIT] = ctrl_reg.differential;
            end
            adc_pkg::RES_LOW_OFS: begin
                read_mux[7:0] = bytes.result_low_byte;
            end
            adc_pkg::RES_HIGH_OFS: begin
                read_mux[7:0] = bytes.result_high_byte;
            end
            adc_pkg::IRQ_STATUS_OFS: begin
                read_mux[adc_pkg::IRQ_DONE_BIT] = done_flag_reg;
            end
            adc_pkg::IRQ_ENABLE_OFS: begin
                read_mux[adc_pkg::IRQ_DONE_BIT] = done_enable_reg;
            end
            adc_pkg::STATE_OFS: begin
                read_mux[adc_pkg::STATE_BUSY_BIT] = timer_busy;
                read_mux[adc_pkg::STATE_FIRST_BIT] = first_pending_reg;
                read_mux[adc_pkg::STATE_SLEEP_BIT] = sleep_started_reg;
            end
            default: begin
                read_mux = adc_pkg::UNMAPPED_READ;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            readdata <= adc_pkg::UNMAPPED_READ;
        end else if (read && waitrequest) begin
            readdata <= read_mux;
        end
    end

endmodule
`default_nettype wire

// file: tb/adc_ctrl_checker.sv
// port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_checker #(
    parameter int CLK_DIV = adc_pkg::CONV_CLK_DIV,
    parameter int NORMAL_CYCLES = adc_pkg::NORMAL_CONV_CYCLES,
    parameter int FIRST_CYCLES = adc_pkg::FIRST_CONV_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic cpu_halted,
    input wire logic [2:0] sleep_mode,
    input wire logic signed [11:0] raw_value,
    input wire logic irq,
    input wire logic converter_powered,
    input wire logic conversion_active,
    input wire logic sample_latch
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    localparam int NL = NORMAL_CYCLES * CLK_DIV;
    localparam int FL = FIRST_CYCLES * CLK_DIV;
    int run_cnt;
    // busy length in system cycles; slack of two covers the one-cycle lag of the copy
    always_ff @(posedge clock) begin
        if (!rst_n || !conversion_active) run_cnt <= 0;
        else run_cnt <= run_cnt + 1;
    end
    sequence clear_commit_s;
        write && !waitrequest && address == adc_pkg::IRQ_CLEAR_OFS && writedata[0] && byteenable[0];
    endsequence
    sequence quiet_halt_s;
        $rose(cpu_halted) && sleep_mode <= 3'h1 && converter_powered && !conversion_active;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    bus_answer_a: assert property (
        (read || write) && waitrequest |=> !waitrequest) else $error("no answer one cycle later");
    sleep_start_a: assert property (
        quiet_halt_s |-> ##[1:3] sample_latch) else $error("sleep halt did not start");
    deep_nostart_a: assert property (
        $rose(cpu_halted) && sleep_mode >= 3'h2 && !write |=> (!sample_latch) [*4])
        else $error("conversion started in deep sleep");
    power_keep_a: assert property (
        cpu_halted && sleep_mode >= 3'h2 && converter_powered && !write && !$past(write)
        |=> converter_powered) else $error("deep sleep turned converter off");
    irq_clear_a: assert property (
        clear_commit_s ##0 !conversion_active ##1 !conversion_active |=> !irq)
        else $error("irq stayed after clear");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(conversion_active) || $past(conversion_active, 2)
        || $past(write, 2) || $past(write, 3)) else $error("irq rose without cause");
    irq_hold_a: assert property (
        irq && !write && !$past(write) |=> irq) else $error("irq dropped by itself");
    conv_len_a: assert property (
        $fell(conversion_active) |-> (run_cnt >= NL - 2 && run_cnt <= NL + 2)
        || (run_cnt >= FL - 2 && run_cnt <= FL + 2)) else $error("conversion length wrong");
    latch_power_a: assert property (
        sample_latch |-> converter_powered) else $error("start taken while disabled");
endmodule
bind adc_ctrl adc_ctrl_checker #(
    .CLK_DIV(CLK_DIV),
    .NORMAL_CYCLES(NORMAL_CYCLES),
    .FIRST_CYCLES(FIRST_CYCLES)
) i_adc_ctrl_checker (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode),
    .raw_value(raw_value), .irq(irq), .converter_powered(converter_powered),
    .conversion_active(conversion_active), .sample_latch(sample_latch)
);
`default_nettype wire

// file: tb/sleep_ctrl_model.sv
// processor core halt and wake model facing the converter control block
`timescale 1ns/100ps
`default_nettype none
module sleep_ctrl_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sleep_go,
    input wire logic [2:0] go_mode,
    input wire logic wake_other,
    input wire logic irq,
    output logic cpu_halted,
    output logic [2:0] sleep_mode
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cpu_halted <= 1'b0;
            sleep_mode <= 3'h0;
        end else if (sleep_go) begin
            cpu_halted <= 1'b1;
            sleep_mode <= go_mode;
        end else if (irq || wake_other) begin
            cpu_halted <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [4:0] CT = adc_pkg::CTRL_OFS;
    localparam logic [4:0] RL = adc_pkg::RES_LOW_OFS;
    localparam logic [4:0] RH = adc_pkg::RES_HIGH_OFS;
    localparam logic [4:0] IS = adc_pkg::IRQ_STATUS_OFS;
    localparam logic [4:0] IC = adc_pkg::IRQ_CLEAR_OFS;
    localparam logic [4:0] IE = adc_pkg::IRQ_ENABLE_OFS;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic signed [11:0] raw_value = 12'sh000;
    logic sleep_go = 1'b0;
    logic [2:0] go_mode = 3'h0;
    logic wake_other = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, irq, converter_powered, conversion_active, sample_latch, cpu_halted;
    logic [2:0] sleep_mode;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [11:0] raws [8] = '{12'h000, 12'h3FF, 12'h7D0, 12'hFFB, 12'hE70, 12'h1FF, 12'h258, 12'hDA8};
    logic [9:0] codes [8] = '{10'h000, 10'h3FF, 10'h3FF, 10'h000, 10'h270, 10'h1FF, 10'h1FF, 10'h200};

    always #10 clock = ~clock;

    adc_ctrl #(.CLK_DIV(1)) i_adc_ctrl (
        .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode),
        .raw_value(raw_value), .irq(irq), .converter_powered(converter_powered),
        .conversion_active(conversion_active), .sample_latch(sample_latch)
    );
    sleep_ctrl_model i_sleep_ctrl_model (
        .clock(clock), .rst_n(rst_n), .sleep_go(sleep_go), .go_mode(go_mode),
        .wake_other(wake_other), .irq(irq), .cpu_halted(cpu_halted), .sleep_mode(sleep_mode)
    );
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low; the timeout ends a hang
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        address <= a;
        writedata <= d;
        read <= rd;
        write <= !rd;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b1, a, 32'h0, q);
        check(q, exp, msg);
    endtask
    task automatic wait_done();
        logic [31:0] q;
        q = 32'h0;
        for (int i = 0; i < 100 && q[0] !== 1'b1; i++) bus(1'b1, IS, 32'h0, q);
    endtask
    task automatic go_sleep(input logic [2:0] m);
        go_mode <= m;
        sleep_go <= 1'b1;
        @(posedge clock);
        sleep_go <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wake_pulse();
        wake_other <= 1'b1;
        @(posedge clock);
        wake_other <= 1'b0;
        @(posedge clock);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_chk(CT, 32'h0, "ctrl reset");
        rd_chk(RL, 32'h0, "low byte reset");
        rd_chk(RH, 32'h0, "high byte reset");
        rd_chk(IS, 32'h0, "status reset");
        rd_chk(5'h1C, adc_pkg::UNMAPPED_READ, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_format();
        logic [9:0] c;
        logic d;
        logic [31:0] q;
        wr(IE, 32'h1);
        // enable before starting, so the first run is the long one
        wr(CT, 32'h1);
        for (int i = 0; i < 8; i++) begin
            c = codes[i];
            d = (i >= 4);
            // input steady per conversion; offset left to software
            raw_value <= raws[i];
            wr(CT, {28'h0, d, 3'b011});
            wait_done();
            check({31'h0, irq}, 32'h1, "irq after done");
            rd_chk(CT, {28'h0, d, 3'b001}, "start bit cleared");
            rd_chk(RL, {24'h0, c[7:0]}, "right low byte");
            rd_chk(RH, {30'h0, c[9:8]}, "right high byte");
            wr(CT, {28'h0, d, 3'b101});
            rd_chk(RH, {24'h0, c[9:2]}, "left high byte");
            rd_chk(RL, {24'h0, c[1:0], 6'h00}, "left low byte");
            bus(1'b1, RH, 32'h0, q);
            if (d) check({31'h0, q[7]}, {31'h0, raws[i][11]}, "sign bit");
            wr(IC, 32'h1);
            rd_chk(IS, 32'h0, "flag cleared");
        end
        $display("test format done");
    endtask
    task automatic t_irq();
        wr(IE, 32'h0);
        raw_value <= 12'h155;
        wr(CT, 32'h3);
        wait_done();
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(IS, 32'h0);
        rd_chk(IS, 32'h1, "status read only");
        wr(IE, 32'h1);
        repeat (3) @(posedge clock);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        wr(IC, 32'h1);
        rd_chk(IS, 32'h0, "cleared status");
        check({31'h0, irq}, 32'h0, "irq dropped");
        $display("test interrupt done");
    endtask
    task automatic t_sleep(input logic [2:0] m);
        // enabled, idle, single mode, interrupt on before sleeping
        wr(CT, 32'h1);
        wr(IE, 32'h1);
        raw_value <= 12'h0AB;
        go_sleep(m);
        for (int i = 0; i < 200 && cpu_halted !== 1'b0; i++) @(posedge clock);
        check({31'h0, cpu_halted}, 32'h0, "woken by done");
        check({31'h0, irq}, 32'h1, "done irq wakes");
        rd_chk(RL, 32'h000000AB, "sleep result");
        rd_chk(CT, 32'h1, "sleep start bit cleared");
        wr(IC, 32'h1);
        $display("test sleep start done");
    endtask
    task automatic t_wake_other();
        go_sleep(3'h1);
        wake_pulse();
        check({31'h0, irq}, 32'h0, "no irq yet");
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clock);
        check({31'h0, irq}, 32'h1, "late done irq");
        wr(IC, 32'h1);
        $display("test other wake done");
    endtask
    task automatic t_deep();
        for (int m = 2; m < 5; m++) begin
            go_sleep(m[2:0]);
            repeat (30) @(posedge clock);
            check({31'h0, conversion_active}, 32'h0, "no deep start");
            check({31'h0, converter_powered}, 32'h1, "stays enabled");
            wake_pulse();
            rd_chk(IS, 32'h0, "no deep result");
        end
        // software powers down after the deep sleep runs
        wr(CT, 32'h0);
        repeat (2) @(posedge clock);
        check({31'h0, converter_powered}, 32'h0, "powered off");
        $display("test deep sleep done");
    endtask
    // ----------------------------------------
    // main sequence and timeout
    // ----------------------------------------
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_format();
        t_irq();
        t_sleep(3'h0);
        t_sleep(3'h1);
        t_wake_other();
        t_deep();
        wrap_up();
    end
endmodule
`default_nettype wire
